// ---- pkg/iap_pkg.sv ----
package iap_pkg;
  // Register offsets within data memory sector 1
  localparam logic [7:0] ADDR_CONTROL_MODE   = 8'h43;
  localparam logic [7:0] ADDR_CHIP_RESET     = 8'h44;
  localparam logic [7:0] ADDR_BUFFER_CLEAR   = 8'h45;
  localparam logic [7:0] ADDR_ADDRESS_LOW    = 8'h46;
  localparam logic [7:0] ADDR_ADDRESS_HIGH   = 8'h47;
  localparam logic [7:0] ADDR_WORD0_LOW      = 8'h48;
  localparam logic [7:0] ADDR_WORD0_HIGH     = 8'h49;
  localparam logic [7:0] ADDR_WORD1_LOW      = 8'h4A;
  localparam logic [7:0] ADDR_WORD1_HIGH     = 8'h4B;
  localparam logic [7:0] ADDR_WORD2_LOW      = 8'h4C;
  localparam logic [7:0] ADDR_WORD2_HIGH     = 8'h4D;
  localparam logic [7:0] ADDR_WORD3_LOW      = 8'h4E;
  localparam logic [7:0] ADDR_WORD3_HIGH     = 8'h4F;
  localparam logic [7:0] BYTE_ZERO           = 8'h00;
  localparam logic [7:0] CHIP_RESET_KEY      = 8'h55;

  // Control register bit positions
  localparam int BIT_UNLOCKED  = 7;
  localparam int BIT_MODE_HI   = 6;
  localparam int BIT_MODE_LO   = 4;
  localparam int BIT_PROC_EN   = 3;
  localparam int BIT_WR_START  = 2;
  localparam int BIT_RD_ENABLE = 1;
  localparam int BIT_RD_START  = 0;

  // Operation select codes
  typedef enum logic [2:0] {
    OP_WORD_WRITE  = 3'h0,
    OP_PAGE_ERASE  = 3'h1,
    OP_WORD_READ   = 3'h3,
    OP_UNLOCK_MODE = 3'h6
  } iap_op_type;

  // Unlock pattern, six bytes in write order
  localparam int PATTERN_LEN = 6;
  localparam logic [7:0] UNLOCK_PATTERN [PATTERN_LEN] =
    '{8'h00, 8'h04, 8'h0D, 8'h09, 8'hC3, 8'h40};

  // Unlock timeout
  localparam int UNLOCK_TIMEOUT_US = 300;
  localparam int SUB_CLOCK_HZ      = 32768;
  localparam int UNLOCK_TIMEOUT_SUB_TICKS =
    (UNLOCK_TIMEOUT_US * SUB_CLOCK_HZ) / 1000000;

  // Widths
  localparam int ADDR_WIDTH = 15;
  localparam int PAGE_WIDTH = 9;
  localparam int PAGE_OFFSET_BITS = 6;
endpackage

// ---- verilog/iap_flash_write_unlock.sv ----
// Function
// - First high byte write loads whole word
// - Buffer load increments flash address
// - Word pairs hold low and high bytes
// - Unlock starts a timeout of 9 sub clock ticks (300 us truncated, about 275 us)
// - Timeout counter runs from sub clock
// - Timeout or bad byte aborts, clears enable
// - Correct pattern unlocks, clears enable, sets status
// - Clearing status relocks; writes refused
// - Page erase spans 64 words, low bits ignored
// - Page number is high address and bits 7:6
// - Start bits stall CPU until cleared
// - Mode codes: write, erase, read, unlock
// - Write start cleared by hardware when done
// - First low byte write only stores
// - Writing one to status has no effect
`timescale 1ns/100ps
`default_nettype none
module iap_flash_write_unlock
  import iap_pkg::*;
#(
  parameter int TIMEOUT_TICKS = UNLOCK_TIMEOUT_SUB_TICKS
)(
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  input  wire logic                  subClockRaw,
  input  wire logic                  regWrite,
  input  wire logic                  regRead,
  input  wire logic [7:0]            regAddr,
  input  wire logic [7:0]            regWriteData,
  output logic      [7:0]            regReadData,
  input  wire logic                  flashOpDone,
  input  wire logic                  bufferClearDone,
  input  wire logic [15:0]           flashReadData,
  output logic      [15:0]           writeBuffer,
  output logic                       writeBufferLoad,
  output logic      [ADDR_WIDTH-1:0] flashAddress,
  output logic      [PAGE_WIDTH-1:0] erasePage,
  output logic      [2:0]            operationSelect,
  output logic                       flashWriteAllowed,
  output logic                       writeStartReq,
  output logic                       readStartReq,
  output logic                       bufferClearReq,
  output logic                       chipResetReq,
  output logic                       cpuStall
);

  ////////////////////////////////////////////////////////////////////////
  // Register decode
  function automatic logic hit(input logic [7:0] a);
    hit = regWrite && (regAddr == a);
  endfunction

  logic [7:0] wordLow  [4];
  logic [7:0] wordHigh [4];
  logic       writeUnlockedStatus;
  logic       unlockProcedureEnable;
  logic       readEnable;
  logic       writeStart;
  logic       readStart;
  logic       bufferClear;
  logic [7:0] chipResetReg;
  logic [7:0] addressLow;
  logic [6:0] addressHigh;

  logic       procActive;
  logic [2:0] patternIndex;
  logic [15:0] timeoutCount;
  logic       subSync1;
  logic       subSync2;
  logic       subPrev;
  logic       subTick;

  ////////////////////////////////////////////////////////////////////////
  // Sub clock synchroniser and rising edge enable
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      subSync1 <= 1'b0;
      subSync2 <= 1'b0;
      subPrev  <= 1'b0;
    end
    else
    begin
      subSync1 <= subClockRaw;
      subSync2 <= subSync1;
      subPrev  <= subSync2;
    end
  end

  assign subTick = subSync2 && !subPrev;

  ////////////////////////////////////////////////////////////////////////
  // Pattern check signals
  logic       patWrite;
  logic       patGood;
  logic [7:0] patAddr;
  logic       timedOut;
  logic       startProc;
  logic       ctrlWrite;

  assign ctrlWrite = hit(ADDR_CONTROL_MODE);
  assign patAddr   = ADDR_WORD1_LOW + {5'h00, patternIndex};
  assign patWrite  = procActive && regWrite &&
                     (regAddr >= ADDR_WORD1_LOW) &&
                     (regAddr <= ADDR_WORD3_HIGH);
  // Byte must land on the expected register with the expected value
  assign patGood   = (regAddr == patAddr) &&
                     (regWriteData == UNLOCK_PATTERN[patternIndex]);
  assign timedOut  = procActive && subTick &&
                     (timeoutCount >= 16'(TIMEOUT_TICKS - 1));
  assign startProc = ctrlWrite && !procActive &&
                     regWriteData[BIT_PROC_EN] &&
                     (regWriteData[BIT_MODE_HI:BIT_MODE_LO] ==
                      OP_UNLOCK_MODE);

  ////////////////////////////////////////////////////////////////////////
  // Unlock sequencer and timeout counter
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      procActive   <= 1'b0;
      patternIndex <= 3'h0;
      timeoutCount <= 16'h0000;
    end
    else if (startProc)
    begin
      procActive   <= 1'b1;
      patternIndex <= 3'h0;
      timeoutCount <= 16'h0000;
    end
    else if (procActive)
    begin
      if (timedOut || (patWrite && !patGood))
        procActive <= 1'b0;
      else if (patWrite &&
               patternIndex == 3'(PATTERN_LEN - 1))
        procActive <= 1'b0;
      else if (patWrite)
        patternIndex <= patternIndex + 3'h1;
      if (subTick)
        timeoutCount <= timeoutCount + 16'h0001;
    end
  end

  logic unlockSuccess;
  assign unlockSuccess = procActive && !timedOut && patWrite &&
                         patGood &&
                         (patternIndex == 3'(PATTERN_LEN - 1));

  ////////////////////////////////////////////////////////////////////////
  // Control register
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      writeUnlockedStatus   <= 1'b0;
      operationSelect       <= 3'h0;
      unlockProcedureEnable <= 1'b0;
      readEnable            <= 1'b0;
    end
    else
    begin
      if (ctrlWrite)
      begin
        operationSelect <= regWriteData[BIT_MODE_HI:BIT_MODE_LO];
        readEnable      <= regWriteData[BIT_RD_ENABLE];
      end
      // Hardware set beats software clear
      if (unlockSuccess)
        writeUnlockedStatus <= 1'b1;
      else if (ctrlWrite && !regWriteData[BIT_UNLOCKED])
        writeUnlockedStatus <= 1'b0;
      // Procedure enable: set by software, cleared on end
      if (procActive && !startProc &&
          (timedOut || (patWrite && !patGood) || unlockSuccess))
        unlockProcedureEnable <= 1'b0;
      else if (ctrlWrite)
        unlockProcedureEnable <= regWriteData[BIT_PROC_EN];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Start bits: software sets, hardware clears
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      writeStart  <= 1'b0;
      readStart   <= 1'b0;
      bufferClear <= 1'b0;
    end
    else
    begin
      if (ctrlWrite && regWriteData[BIT_WR_START] &&
          writeUnlockedStatus)
        writeStart <= 1'b1;
      else if (flashOpDone)
        writeStart <= 1'b0;
      if (ctrlWrite && regWriteData[BIT_RD_START])
        readStart <= 1'b1;
      else if (flashOpDone)
        readStart <= 1'b0;
      if (hit(ADDR_BUFFER_CLEAR) && regWriteData[0])
        bufferClear <= 1'b1;
      else if (bufferClearDone)
        bufferClear <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Address pair with auto increment
  logic [ADDR_WIDTH-1:0] next_address;
  assign next_address = {addressHigh, addressLow} + 15'h0001;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      addressLow  <= 8'h00;
      addressHigh <= 7'h00;
    end
    else if (hit(ADDR_WORD0_HIGH))
    begin
      addressLow  <= next_address[7:0];
      addressHigh <= next_address[ADDR_WIDTH-1:8];
    end
    else
    begin
      if (hit(ADDR_ADDRESS_LOW))
        addressLow <= regWriteData;
      if (hit(ADDR_ADDRESS_HIGH))
        addressHigh <= regWriteData[6:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Data word pairs; read completion fills the first pair
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_word
      always_ff @(posedge clk or posedge sys_rst)
      begin
        if (sys_rst)
        begin
          wordLow[gi]  <= 8'h00;
          wordHigh[gi] <= 8'h00;
        end
        else
        begin
          if (gi == 0 && readStart && flashOpDone)
          begin
            wordLow[gi]  <= flashReadData[7:0];
            wordHigh[gi] <= flashReadData[15:8];
          end
          else
          begin
            if (hit(ADDR_WORD0_LOW + 8'(2 * gi)))
              wordLow[gi] <= regWriteData;
            if (hit(ADDR_WORD0_HIGH + 8'(2 * gi)))
              wordHigh[gi] <= regWriteData;
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Write buffer load from the first pair
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      writeBuffer     <= 16'h0000;
      writeBufferLoad <= 1'b0;
    end
    else
    begin
      writeBufferLoad <= hit(ADDR_WORD0_HIGH);
      if (hit(ADDR_WORD0_HIGH))
        writeBuffer <= {regWriteData, wordLow[0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Chip reset key register
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      chipResetReg <= 8'h00;
    else if (hit(ADDR_CHIP_RESET))
      chipResetReg <= regWriteData;
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  assign flashAddress      = {addressHigh, addressLow};
  assign erasePage         = {addressHigh,
                              addressLow[7:PAGE_OFFSET_BITS]};
  assign flashWriteAllowed = writeUnlockedStatus;
  assign writeStartReq     = writeStart;
  assign readStartReq      = readStart && readEnable;
  assign bufferClearReq    = bufferClear;
  assign chipResetReq      = (chipResetReg == CHIP_RESET_KEY);
  assign cpuStall          = writeStart || readStart;

  ////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped reads return zero
  always_comb
  begin
    regReadData = BYTE_ZERO;
    if (regRead)
    begin
      case (regAddr)
        ADDR_CONTROL_MODE: regReadData = {writeUnlockedStatus,
                                          operationSelect,
                                          unlockProcedureEnable,
                                          writeStart, readEnable,
                                          readStart};
        ADDR_CHIP_RESET:   regReadData = chipResetReg;
        ADDR_BUFFER_CLEAR: regReadData = {7'h00, bufferClear};
        ADDR_ADDRESS_LOW:  regReadData = addressLow;
        ADDR_ADDRESS_HIGH: regReadData = {1'b0, addressHigh};
        ADDR_WORD0_LOW:    regReadData = wordLow[0];
        ADDR_WORD0_HIGH:   regReadData = wordHigh[0];
        ADDR_WORD1_LOW:    regReadData = wordLow[1];
        ADDR_WORD1_HIGH:   regReadData = wordHigh[1];
        ADDR_WORD2_LOW:    regReadData = wordLow[2];
        ADDR_WORD2_HIGH:   regReadData = wordHigh[2];
        ADDR_WORD3_LOW:    regReadData = wordLow[3];
        ADDR_WORD3_HIGH:   regReadData = wordHigh[3];
        default:           regReadData = BYTE_ZERO;
      endcase
    end
  end

endmodule // iap_flash_write_unlock
`default_nettype wire

// ---- tb/iap_flash_write_unlock_sva.sv ----
`timescale 1ns/100ps
`default_nettype none
module iap_flash_write_unlock_sva
  import iap_pkg::*;
#(
  parameter int TIMEOUT_TICKS = UNLOCK_TIMEOUT_SUB_TICKS
)(
  input wire logic                  clk,
  input wire logic                  sys_rst,
  input wire logic                  subClockRaw,
  input wire logic                  regWrite,
  input wire logic                  regRead,
  input wire logic [7:0]            regAddr,
  input wire logic [7:0]            regWriteData,
  input wire logic [7:0]            regReadData,
  input wire logic                  flashOpDone,
  input wire logic                  bufferClearDone,
  input wire logic [15:0]           flashReadData,
  input wire logic [15:0]           writeBuffer,
  input wire logic                  writeBufferLoad,
  input wire logic [ADDR_WIDTH-1:0] flashAddress,
  input wire logic [PAGE_WIDTH-1:0] erasePage,
  input wire logic [2:0]            operationSelect,
  input wire logic                  flashWriteAllowed,
  input wire logic                  writeStartReq,
  input wire logic                  readStartReq,
  input wire logic                  bufferClearReq,
  input wire logic                  chipResetReq,
  input wire logic                  cpuStall
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // Decoded write strobes
  logic       hiWr;
  logic       loWr;
  logic       ctlWr;
  logic [2:0] wrMode;
  assign hiWr = regWrite && (regAddr == ADDR_WORD0_HIGH);
  assign loWr = regWrite && (regAddr == ADDR_WORD0_LOW);
  assign ctlWr = regWrite && (regAddr == ADDR_CONTROL_MODE);
  assign wrMode = regWriteData[6:4];

  //////////////////////////////////////////////////////////////////////////
  a_load_word: assert property (hiWr |=> writeBufferLoad
    && writeBuffer[15:8] == $past(regWriteData)) else $error("no load");
  a_addr_step: assert property (hiWr |=>
    flashAddress == 15'($past(flashAddress) + 1)) else $error("no step");
  a_low_only: assert property (loWr |=>
    !writeBufferLoad && $stable(writeBuffer)) else $error("low loads");
  a_page_map: assert property (erasePage ==
    {flashAddress[14:8], flashAddress[7:6]}) else $error("bad page");
  a_stall_cpu: assert property ((writeStartReq || readStartReq)
    |-> cpuStall) else $error("no stall");
  a_done_clears: assert property (flashOpDone && !regWrite
    |=> !writeStartReq && !readStartReq) else $error("start kept");
  a_status_set: assert property (ctlWr && !flashWriteAllowed
    |=> !flashWriteAllowed) else $error("status set by write");
  a_status_clear: assert property (ctlWr && !regWriteData[7]
    |=> !flashWriteAllowed) else $error("status kept");
  a_start_refused: assert property (ctlWr && !flashWriteAllowed
    && !writeStartReq |=> !writeStartReq) else $error("start taken");
  a_mode_field: assert property (ctlWr |=>
    operationSelect == $past(wrMode)) else $error("bad mode");
endmodule // iap_flash_write_unlock_sva

bind iap_flash_write_unlock iap_flash_write_unlock_sva #(
  .TIMEOUT_TICKS(TIMEOUT_TICKS)
) iap_flash_write_unlock_sva_inst (
  .clk(clk), .sys_rst(sys_rst), .subClockRaw(subClockRaw),
  .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
  .regWriteData(regWriteData), .regReadData(regReadData),
  .flashOpDone(flashOpDone), .bufferClearDone(bufferClearDone),
  .flashReadData(flashReadData), .writeBuffer(writeBuffer),
  .writeBufferLoad(writeBufferLoad), .flashAddress(flashAddress),
  .erasePage(erasePage), .operationSelect(operationSelect),
  .flashWriteAllowed(flashWriteAllowed), .writeStartReq(writeStartReq),
  .readStartReq(readStartReq), .bufferClearReq(bufferClearReq),
  .chipResetReq(chipResetReq), .cpuStall(cpuStall)
);
`default_nettype wire

// ---- tb/iap_flash_write_unlock_test.sv ----
`timescale 1ns/100ps
`default_nettype none
module iap_flash_write_unlock_test import iap_pkg::*;;
  localparam int TO = 3;
  localparam logic [7:0] CTL = ADDR_CONTROL_MODE;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic subClockRaw = 1'b0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic flashOpDone = 1'b0;
  logic bufferClearDone = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWriteData = 8'h00;
  logic [15:0] flashReadData = 16'hBEEF;
  logic [7:0] regReadData;
  logic [15:0] writeBuffer;
  logic [ADDR_WIDTH-1:0] flashAddress;
  logic [PAGE_WIDTH-1:0] erasePage;
  logic [2:0] operationSelect;
  logic writeBufferLoad, flashWriteAllowed, writeStartReq, readStartReq;
  logic bufferClearReq, chipResetReq, cpuStall;
  int errors = 0;
  int n_compared = 0;

  // Device under test
  iap_flash_write_unlock #(.TIMEOUT_TICKS(TO)) iap_flash_write_unlock_inst (
    .clk(clk), .sys_rst(sys_rst), .subClockRaw(subClockRaw),
    .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
    .regWriteData(regWriteData), .regReadData(regReadData),
    .flashOpDone(flashOpDone), .bufferClearDone(bufferClearDone),
    .flashReadData(flashReadData), .writeBuffer(writeBuffer),
    .writeBufferLoad(writeBufferLoad), .flashAddress(flashAddress),
    .erasePage(erasePage), .operationSelect(operationSelect),
    .flashWriteAllowed(flashWriteAllowed), .writeStartReq(writeStartReq),
    .readStartReq(readStartReq), .bufferClearReq(bufferClearReq),
    .chipResetReq(chipResetReq), .cpuStall(cpuStall)
  );

  always #20 clk = ~clk;

  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Write held high, lowered by the next idle, read or ticks
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regAddr = a;
    regWriteData = d;
    regWrite = 1'b1;
    regRead = 1'b0;
    @(posedge clk);
    #1;
  endtask

  task automatic idle();
    regWrite = 1'b0;
    regRead = 1'b0;
    @(posedge clk);
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    regWrite = 1'b0;
    regAddr = a;
    regRead = 1'b1;
    #2;
    chk({8'h00, regReadData}, e);
    @(posedge clk);
    #1;
  endtask

  // Sub clock pulses, slow against clk
  task automatic ticks(input int n);
    regWrite = 1'b0;
    regRead = 1'b0;
    repeat (n)
    begin
      subClockRaw = 1'b1;
      repeat (5) @(posedge clk);
      #1;
      subClockRaw = 1'b0;
      repeat (5) @(posedge clk);
      #1;
    end
  endtask

  task automatic done();
    flashOpDone = 1'b1;
    @(posedge clk);
    #1;
    flashOpDone = 1'b0;
  endtask

  task automatic pattern();
    for (int i = 0; i < PATTERN_LEN; i++)
      wr(8'(ADDR_WORD1_LOW + i), UNLOCK_PATTERN[i]);
  endtask

  //////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    for (int a = 8'h42; a <= 8'h50; a++)
      rd(8'(a), 16'h0000);
    chk(flashWriteAllowed, 16'h0000);
  endtask

  // Key register, buffer clear and read gated by read enable
  task automatic t_misc();
    wr(ADDR_CHIP_RESET, CHIP_RESET_KEY);
    idle();
    chk(16'(chipResetReq), 16'h0001);
    wr(ADDR_CHIP_RESET, 8'h54);
    idle();
    chk(16'(chipResetReq), 16'h0000);
    wr(ADDR_BUFFER_CLEAR, 8'h01);
    idle();
    chk(16'(bufferClearReq), 16'h0001);
    bufferClearDone = 1'b1;
    @(posedge clk);
    #1;
    bufferClearDone = 1'b0;
    chk(16'(bufferClearReq), 16'h0000);
    wr(CTL, 8'h81);
    idle();
    chk({readStartReq, cpuStall}, 16'h0001);
    done();
    chk(16'(cpuStall), 16'h0000);
  endtask

  task automatic t_pairs();
    for (int i = 0; i < 6; i++)
      wr(8'(ADDR_WORD1_LOW + i), 8'(8'hA0 + i));
    for (int i = 0; i < 6; i++)
      rd(8'(ADDR_WORD1_LOW + i), 16'(8'hA0 + i));
  endtask

  task automatic t_bad_byte();
    wr(CTL, 8'h68);
    rd(CTL, 16'h0068);
    wr(ADDR_WORD1_LOW, 8'h00);
    wr(ADDR_WORD1_HIGH, 8'h05);
    rd(CTL, 16'h0060);
    wr(CTL, 8'hE0);
    rd(CTL, 16'h0060);
  endtask

  task automatic t_timeout();
    wr(CTL, 8'h68);
    ticks(TO);
    pattern();
    rd(CTL, 16'h0060);
    chk(flashWriteAllowed, 16'h0000);
  endtask

  task automatic t_unlock();
    wr(CTL, 8'h68);
    ticks(TO - 1);
    pattern();
    rd(CTL, 16'h00E0);
    chk(flashWriteAllowed, 16'h0001);
  endtask

  task automatic t_buffer();
    wr(ADDR_ADDRESS_LOW, 8'hFF);
    wr(ADDR_ADDRESS_HIGH, 8'h7F);
    wr(ADDR_WORD0_LOW, 8'h34);
    wr(ADDR_WORD0_HIGH, 8'h12);
    chk(writeBufferLoad, 16'h0001);
    chk(writeBuffer, 16'h1234);
    chk(flashAddress, 16'h0000);
    wr(ADDR_WORD0_HIGH, 8'h56);
    chk(writeBuffer, 16'h5634);
    chk(flashAddress, 16'h0001);
    wr(ADDR_WORD0_LOW, 8'h99);
    chk(writeBufferLoad, 16'h0000);
    chk(writeBuffer, 16'h5634);
    wr(ADDR_ADDRESS_LOW, 8'hC5);
    wr(ADDR_ADDRESS_HIGH, 8'h7F);
    idle();
    chk(erasePage, 16'h01FF);
    wr(ADDR_ADDRESS_LOW, 8'h7F);
    wr(ADDR_ADDRESS_HIGH, 8'h00);
    idle();
    chk(erasePage, 16'h0001);
  endtask

  task automatic t_ops();
    logic [2:0] codes [4];
    codes = '{3'h0, 3'h1, 3'h3, 3'h6};
    wr(CTL, 8'h83);
    idle();
    chk({readStartReq, cpuStall}, 16'h0003);
    done();
    chk(cpuStall, 16'h0000);
    rd(ADDR_WORD0_LOW, 16'h00EF);
    rd(ADDR_WORD0_HIGH, 16'h00BE);
    wr(CTL, 8'h94);
    idle();
    chk({writeStartReq, cpuStall}, 16'h0003);
    done();
    chk(writeStartReq, 16'h0000);
    wr(CTL, 8'h84);
    idle();
    chk({writeStartReq, cpuStall}, 16'h0003);
    done();
    chk(writeStartReq, 16'h0000);
    for (int i = 0; i < 4; i++)
    begin
      wr(CTL, {1'b1, codes[i], 4'h0});
      idle();
      chk(operationSelect, 16'(codes[i]));
    end
    wr(CTL, 8'h00);
    wr(CTL, 8'h04);
    idle();
    chk({flashWriteAllowed, writeStartReq}, 16'h0000);
  endtask

  //////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (12) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    t_reset();
    t_misc();
    t_pairs();
    t_bad_byte();
    t_timeout();
    t_unlock();
    t_buffer();
    t_ops();
    end_of_test();
  end

  // Hang guard
  initial
  begin
    #2000000;
    errors++;
    end_of_test();
  end
endmodule // iap_flash_write_unlock_test
`default_nettype wire
